// >>> otp_host_model.sv
// Host model: serial clock bursts and the shared program pin wire.
// Assumes go_i is a one-cycle request; link period is 200 ns.
`timescale 1ns/1ps
module otp_host_model
(
    input  wire logic       go_i,
    input  wire logic [5:0] count_i,
    input  wire logic       pin_drive_i,
    input  wire logic       pin_oe_n_i,
    output logic            sclk_o,
    output logic            busy_o,
    output logic            pin_level_o
);
    // block drives the pin when enabled, else host holds it high
    assign pin_level_o = pin_oe_n_i ? 1'h1 : pin_drive_i;

    // Clock stands low between frames; odd offset keeps its rise off the edges
    initial
    begin
        sclk_o = 1'h0;
        busy_o = 1'h0;
        forever
        begin
            @(posedge go_i);
            busy_o = 1'h1;
            repeat (count_i)
            begin
                #90 sclk_o = 1'h1;
                #110 sclk_o = 1'h0;
            end
            busy_o = 1'h0;
        end
    end
endmodule

// >>> otp_turn_counter_status.sv
// Fuse programming and verification, multi-turn counter, lock flag and
// field strength indicators of the angle sensor's digital core.
// Assumes decoded serial commands on a plain register port, sensor
// values on clock_i and a raw serial clock pin from the host.
//
// Function
// [R1] Fuse bits 16 to 45 are factory trim, never changed by burning.
// [R2] Host supplies the burn pattern through command 25.
// [R3] Command 0FH returns the fuse register in the burn layout.
// [R4] Command 09H drives the program pin, one fuse bit per serial clock.
// [R5] Redundancy replaces one customer bit, forcing it to one only.
// [R6] Field 15:12: 0 none, 1..12 bits 0..11, 13..15 none.
// [R7] An eight-bit revolution counter tracks full magnet turns.
// [R8] Each angle zero crossing steps the counter up or down.
// [R9] Any reset leaves the revolution counter at zero.
// [R10] Count is two's complement, +127 to -128, all ones is -1.
// [R11] Clockwise rising angle counts up, counter-clockwise counts down.
// [R12] Clear bit of command 19 zeroes counter on the rising serial edge.
// [R13] Crossings after that clearing edge still change the counter.
// [R14] Lock reads one when converter locked and angle valid, else zero.
// [R15] Host trusts angle only with lock and gain strictly inside range.
// [R16] Low-field pin high while gain below 3FH, low at 3FH.
// [R17] Angle read carries the six-bit gain value.
// [R18] Gain rises with weak field, falls with strong field.
// [R19] Fuse sensitivity field maps directly onto three-bit gain setting.
// [R20] Integrator sets sensitivity so gain sits near 32.
// [R21] Host stores nominal gain and flags a push on departure.
// [R22] Customer burn touches fuse bits 0 to 15 only.
// [R23] In low power mode both angle and turn reads show lock zero.
// [R24] Clear bit of the hysteresis command sets the counter to zero.
// [R25] Counter wraps modulo 256 in both directions.
`timescale 1ns/1ps

module otp_turn_counter_status
#(
    // Factory trim content; value is arbitrary
    parameter logic [29:0] FACTORY_TRIM = 30'h0000_0000
)
(
    input  wire logic                          clock_i,
    input  wire logic                          resetn_i,
    input  wire logic [otp_turn_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [otp_turn_pkg::WDATA_W-1:0] wr_data_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    input  wire otp_turn_pkg::sensor_s         sensor_i,
    input  wire logic                          serial_clock_pin_i,
    input  wire logic                          fuse_program_pin_i,
    output logic [otp_turn_pkg::DATA_W-1:0]    rd_data_o,
    output logic                               fuse_program_pin_o,
    output logic                               fuse_program_pin_oe_n_o,
    output logic                               low_field_flag_pin_o,
    output logic [otp_turn_pkg::SENS_W-1:0]    gain_setting_o
);

    // Redundancy remap; a bad fuse can only be overridden to one
    // Codes above the last replaceable bit decode as no replacement, so a
    // half-programmed field never forces a bit of the field itself
    function automatic logic [15:0] apply_redundancy
    (
        input logic [15:0] raw
    );
        logic [15:0] fixed;
        logic [3:0]  sel;
        fixed = raw;
        sel   = raw[otp_turn_pkg::RED_LO +: otp_turn_pkg::RED_W];
        // [R6] Field decode
        if (sel != otp_turn_pkg::RED_NONE && sel <= otp_turn_pkg::RED_MAX)
        begin
            // [R5] Force to one
            fixed[sel - 4'h1] = 1'b1;
        end
        return fixed;
    endfunction

    // Status word: flag, gain, payload, even parity
    // Shared by angle and turn reads so both keep one bit layout
    function automatic logic [15:0] status_word
    (
        input logic       lock,
        input logic [5:0] agc,
        input logic [7:0] payload
    );
        logic [14:0] body;
        body = {lock, agc, payload};
        return {body, ^body};
    endfunction

    otp_turn_pkg::state_s state_reg;
    otp_turn_pkg::state_s state_next;

    logic [otp_turn_pkg::FUSE_W-1:0] fuse_raw;
    logic [otp_turn_pkg::FUSE_W-1:0] fuse_eff;
    logic                            sclk_rise;
    logic                            lock_seen;
    logic                            cross_up;
    logic                            cross_down;

    // [R1] Trim bits come from a constant, never from the burn path
    assign fuse_raw = {FACTORY_TRIM, state_reg.fuse_cust};
    assign fuse_eff = {FACTORY_TRIM, apply_redundancy(state_reg.fuse_cust)};

    // Rising edge of the synchronised serial clock
    // Only the second stage feeds the detector; the first may still be
    // settling. Costs three clock cycles of latency per serial edge,
    // well inside the slow serial clock period.
    assign sclk_rise = state_reg.sclk_sync & ~state_reg.sclk_prev;

    // [R14] Lock reported as delivered; [R23] forced low in sleep
    assign lock_seen = sensor_i.lock & ~state_reg.sleep;

    // [R11] Wrap through zero upward means clockwise
    assign cross_up   = state_reg.angle_prev[7:6] == otp_turn_pkg::QUAD_HIGH
                     && sensor_i.angle[7:6] == otp_turn_pkg::QUAD_LOW;
    assign cross_down = state_reg.angle_prev[7:6] == otp_turn_pkg::QUAD_LOW
                     && sensor_i.angle[7:6] == otp_turn_pkg::QUAD_HIGH;

    // Next-state logic for the whole block
    always_comb
    begin
        state_next = state_reg;

        // Two stages before the pin is looked at; meta feeds sync only
        state_next.sclk_meta  = serial_clock_pin_i;
        state_next.sclk_sync  = state_reg.sclk_meta;
        state_next.sclk_prev  = state_reg.sclk_sync;
        state_next.angle_prev = sensor_i.angle;

        // Read data stands for exactly one cycle
        state_next.rdata = '0;
        if (rd_i)
        begin
            case (addr_i)
                otp_turn_pkg::CMD_RD_ANGLE:
                begin
                    // [R17] Gain travels with the angle
                    state_next.rdata = {32'h0000_0000,
                        status_word(lock_seen, sensor_i.agc,
                                    sensor_i.angle)};
                end
                otp_turn_pkg::CMD_RD_TURNS:
                begin
                    // [R10] Count returned as raw two's complement
                    state_next.rdata = {32'h0000_0000,
                        status_word(lock_seen, sensor_i.agc,
                                    state_reg.turns)};
                end
                otp_turn_pkg::CMD_RD_FUSE:
                begin
                    // [R3] Same layout as the burn pattern
                    state_next.rdata = {2'b00, fuse_eff};
                end
                default:
                begin
                    state_next.rdata = '0;
                end
            endcase
        end

        // Decoded command writes
        if (wr_i)
        begin
            case (addr_i)
                otp_turn_pkg::CMD_BURN:
                begin
                    // [R22] Only customer bits; fuses only blow to one
                    state_next.fuse_cust = state_reg.fuse_cust | wr_data_i;
                end
                otp_turn_pkg::CMD_CONFIG:
                begin
                    state_next.sleep = wr_data_i[otp_turn_pkg::SLEEP_BIT];
                end
                otp_turn_pkg::CMD_HYST:
                begin
                    // [R24] Clear request waits for its serial edge
                    if (wr_data_i[otp_turn_pkg::CLEAR_BIT])
                    begin
                        state_next.clear_armed = 1'b1;
                    end
                end
                default:
                begin
                    state_next.clear_armed = state_reg.clear_armed;
                end
            endcase
        end

        // [R12] Clear lands on the rising serial edge of the bit
        // A fresh arm written in the consuming cycle survives (set wins)
        if (state_reg.clear_armed && sclk_rise)
        begin
            state_next.turns       = otp_turn_pkg::TURN_RESET;
            state_next.clear_armed = wr_i
                && addr_i == otp_turn_pkg::CMD_HYST
                && wr_data_i[otp_turn_pkg::CLEAR_BIT];
        end

        // [R8] Step on a crossing; [R13] also right after a clear
        // [R25] Plain eight-bit add wraps modulo 256
        // Limitation: the angle must move less than a quarter turn per
        // clock, or a crossing is missed or counted the wrong way
        if (cross_up)
        begin
            state_next.turns = state_next.turns + 8'h01;
        end
        else if (cross_down)
        begin
            state_next.turns = state_next.turns - 8'h01;
        end

        // Analog readout sequencer; any other strobe ends it early
        // Raw bits are shown, not the remapped ones, so a weak fuse
        // stays visible even when redundancy already covers it
        case (state_reg.mode)
            otp_turn_pkg::MODE_IDLE:
            begin
                state_next.pin_oe_n = 1'b1;
                // [R4] Program pin turns into an output
                if (rd_i && addr_i == otp_turn_pkg::CMD_RD_ANALOG)
                begin
                    state_next.mode      = otp_turn_pkg::MODE_ANALOG;
                    state_next.bit_idx   = 6'h00;
                    state_next.pin_level = 1'b0;
                    state_next.pin_oe_n  = 1'b0;
                end
            end
            otp_turn_pkg::MODE_ANALOG:
            begin
                if (wr_i || (rd_i && addr_i != otp_turn_pkg::CMD_RD_ANALOG))
                begin
                    state_next.mode     = otp_turn_pkg::MODE_IDLE;
                    state_next.pin_oe_n = 1'b1;
                end
                else if (sclk_rise)
                begin
                    // [R4] Next physical fuse bit per serial clock
                    if (state_reg.bit_idx > otp_turn_pkg::FUSE_LAST)
                    begin
                        state_next.mode      = otp_turn_pkg::MODE_IDLE;
                        state_next.pin_oe_n  = 1'b1;
                        state_next.pin_level = 1'b0;
                    end
                    else
                    begin
                        state_next.pin_level = fuse_raw[state_reg.bit_idx];
                        state_next.bit_idx   = state_reg.bit_idx + 6'h01;
                    end
                end
            end
            default:
            begin
                state_next.mode     = otp_turn_pkg::MODE_IDLE;
                state_next.pin_oe_n = 1'b1;
            end
        endcase

        // [R16] Pin drops only when gain saturates at its top
        // [R18] Gain loop itself is analog; only its value is seen here
        state_next.low_field = sensor_i.agc != otp_turn_pkg::AGC_TOP;

        // [R19] Sensitivity field drives the gain setting directly
        state_next.gain =
            fuse_eff[otp_turn_pkg::SENS_LO +: otp_turn_pkg::SENS_W];
    end

    // State register; reset values are constants only
    // Customer fuses are modelled as volatile flops and clear on reset
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg.mode        <= otp_turn_pkg::MODE_IDLE;
            // [R9] Counter starts at zero
            state_reg.turns       <= otp_turn_pkg::TURN_RESET;
            state_reg.fuse_cust   <= 16'h0000;
            state_reg.sleep       <= 1'b0;
            state_reg.clear_armed <= 1'b0;
            state_reg.bit_idx     <= 6'h00;
            state_reg.pin_level   <= 1'b0;
            state_reg.pin_oe_n    <= 1'b1;
            state_reg.low_field   <= 1'b1;
            state_reg.gain        <= 3'h0;
            state_reg.rdata       <= '0;
            state_reg.sclk_meta   <= 1'b0;
            state_reg.sclk_sync   <= 1'b0;
            state_reg.sclk_prev   <= 1'b0;
            state_reg.angle_prev  <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from state flops
    assign rd_data_o               = state_reg.rdata;
    assign fuse_program_pin_o      = state_reg.pin_level;
    assign fuse_program_pin_oe_n_o = state_reg.pin_oe_n;
    assign low_field_flag_pin_o    = state_reg.low_field;
    assign gain_setting_o          = state_reg.gain;

endmodule

// >>> otp_turn_pkg.sv
// Constants, field layouts, command codes and carrier types for the
// fuse, turn counter and field status logic.
// Assumes a single 40 MHz clock domain; sensor values arrive on it.
package otp_turn_pkg;

    // Register port and fuse layout
    localparam int          DATA_W      = 48;
    localparam int          ADDR_W      = 5;
    localparam int          WDATA_W     = 16;
    localparam int          FUSE_W      = 46;
    localparam int          CUST_W      = 16;
    localparam int          TRIM_W      = 30;
    localparam int          TRIM_LO     = 16;
    localparam int          RED_LO      = 12;
    localparam int          RED_W       = 4;
    localparam int          SENS_LO     = 9;
    localparam int          SENS_W      = 3;
    localparam logic [3:0]  RED_NONE    = 4'h0;
    localparam logic [3:0]  RED_MAX     = 4'hC;
    localparam logic [5:0]  FUSE_LAST   = 6'h2D;

    // Sensor side widths and limits
    localparam int          AGC_W       = 6;
    localparam int          ANG_W       = 8;
    localparam int          TURN_W      = 8;
    localparam logic [5:0]  AGC_TOP     = 6'h3F;
    localparam logic [7:0]  TURN_RESET  = 8'h00;
    localparam logic [1:0]  QUAD_HIGH   = 2'h3;
    localparam logic [1:0]  QUAD_LOW    = 2'h0;

    // Command numbers, used as register port addresses
    localparam logic [4:0]  CMD_RD_ANGLE  = 5'h00;
    localparam logic [4:0]  CMD_RD_TURNS  = 5'h01;
    localparam logic [4:0]  CMD_RD_ANALOG = 5'h09;
    localparam logic [4:0]  CMD_RD_FUSE   = 5'h0F;
    localparam logic [4:0]  CMD_CONFIG    = 5'h11;
    localparam logic [4:0]  CMD_HYST      = 5'h13;
    localparam logic [4:0]  CMD_BURN      = 5'h19;

    // Bit positions inside written command data
    localparam int          SLEEP_BIT   = 0;
    localparam int          CLEAR_BIT   = 0;

    // Analog readout sequencer
    typedef enum logic [1:0]
    {
        MODE_IDLE   = 2'b01,
        MODE_ANALOG = 2'b10
    } mode_e;

    // Values from the tracking converter and gain loop
    typedef struct packed
    {
        logic               lock;
        logic [AGC_W-1:0]   agc;
        logic [ANG_W-1:0]   angle;
    } sensor_s;

    // Complete block state
    typedef struct packed
    {
        mode_e              mode;
        logic [TURN_W-1:0]  turns;
        logic [CUST_W-1:0]  fuse_cust;
        logic               sleep;
        logic               clear_armed;
        logic [5:0]         bit_idx;
        logic               pin_level;
        logic               pin_oe_n;
        logic               low_field;
        logic [SENS_W-1:0]  gain;
        logic [DATA_W-1:0]  rdata;
        logic               sclk_meta;
        logic               sclk_sync;
        logic               sclk_prev;
        logic [ANG_W-1:0]   angle_prev;
    } state_s;

endpackage

// >>> otp_turn_sva.sv
// Checker for the fuse, turn counter and field status block.
// Assumes a bind onto the block; it sees only the block's ports.
`timescale 1ns/1ps
module otp_turn_sva
#(
    parameter logic [29:0] FACTORY_TRIM = 30'h0000_0000
)
(
    input wire logic                             clock_i,
    input wire logic                             resetn_i,
    input wire logic [otp_turn_pkg::ADDR_W-1:0]  addr_i,
    input wire logic [otp_turn_pkg::WDATA_W-1:0] wr_data_i,
    input wire logic                             wr_i,
    input wire logic                             rd_i,
    input wire otp_turn_pkg::sensor_s            sensor_i,
    input wire logic                             serial_clock_pin_i,
    input wire logic                             fuse_program_pin_i,
    input wire logic [otp_turn_pkg::DATA_W-1:0]  rd_data_o,
    input wire logic                             fuse_program_pin_o,
    input wire logic                             fuse_program_pin_oe_n_o,
    input wire logic                             low_field_flag_pin_o,
    input wire logic [otp_turn_pkg::SENS_W-1:0]  gain_setting_o
);
    logic [2:0] since_rise;
    logic       sclk_last;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    // Age of the last raw serial clock rise; saturates so it never wraps
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            since_rise <= 3'h7;
            sclk_last  <= 1'h0;
        end
        else
        begin
            sclk_last <= serial_clock_pin_i;
            if (serial_clock_pin_i && !sclk_last)
                since_rise <= 3'h0;
            else if (since_rise != 3'h7)
                since_rise <= since_rise + 3'h1;
        end
    end

    a_field_high: assert property (
        $past(resetn_i) && $past(sensor_i.agc) != otp_turn_pkg::AGC_TOP
        |-> low_field_flag_pin_o) else $error("low field pin low");
    a_field_low: assert property (
        $past(resetn_i) && $past(sensor_i.agc) == otp_turn_pkg::AGC_TOP
        |-> !low_field_flag_pin_o) else $error("low field pin high");
    a_trim_kept: assert property (
        $past(rd_i) && $past(addr_i) == otp_turn_pkg::CMD_RD_FUSE
        |-> rd_data_o[47:16] == {2'h0, FACTORY_TRIM})
        else $error("trim bits differ");
    a_lock_low: assert property (
        $past(rd_i) && $past(addr_i) == otp_turn_pkg::CMD_RD_ANGLE
        && !$past(sensor_i.lock) |-> !rd_data_o[15])
        else $error("lock shown while unlocked");
    a_agc_angle: assert property (
        $past(rd_i) && $past(addr_i) == otp_turn_pkg::CMD_RD_ANGLE
        |-> rd_data_o[14:1] == $past(sensor_i[13:0]))
        else $error("gain or angle field wrong");
    a_gain_map: assert property (
        $past(rd_i) && $past(addr_i) == otp_turn_pkg::CMD_RD_FUSE
        |-> rd_data_o[11:9] == gain_setting_o)
        else $error("gain setting differs from fuse");
    a_pin_driven: assert property (
        $past(rd_i) && $past(addr_i) == otp_turn_pkg::CMD_RD_ANALOG
        |-> !fuse_program_pin_oe_n_o) else $error("pin not driven");
    a_pin_timing: assert property (
        $changed(fuse_program_pin_o) && !fuse_program_pin_oe_n_o
        && !$past(fuse_program_pin_oe_n_o) |-> since_rise inside {[1:5]})
        else $error("pin moved without serial edge");
    a_write_release: assert property (
        $past(resetn_i) && $past(wr_i) |-> fuse_program_pin_oe_n_o)
        else $error("pin still driven after write");
endmodule

// >>> test_otp_turn_counter_status.sv
// Bench for the fuse, turn counter and field status block.
// Assumes the host model file and the checker bound at the foot.
`timescale 1ns/1ps
module test_otp_turn_counter_status;
    localparam logic [29:0] TRIM = 30'h2AC3_5A0F;
    logic                  clock_i, resetn_i, wr_i, rd_i, go, sleep;
    logic [4:0]            addr;
    logic [15:0]           wdata;
    logic [47:0]           rdata, exp;
    logic [5:0]            cnt;
    logic                  sclk, busy, pin_o, oe_n, pin_lvl, low_f;
    logic [2:0]            gain;
    otp_turn_pkg::sensor_s sens;
    int                    n_fail = 0;
    int                    total_checks = 0;

    otp_turn_counter_status #(.FACTORY_TRIM(TRIM)) dut_u
    (
        .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr),
        .wr_data_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .sensor_i(sens),
        .serial_clock_pin_i(sclk), .fuse_program_pin_i(pin_lvl),
        .rd_data_o(), .fuse_program_pin_o(pin_o),
        .fuse_program_pin_oe_n_o(oe_n), .low_field_flag_pin_o(low_f),
        .gain_setting_o(gain)
    );
    otp_host_model host_u
    (
        .go_i(go), .count_i(cnt), .pin_drive_i(pin_o),
        .pin_oe_n_i(oe_n), .sclk_o(sclk), .busy_o(busy),
        .pin_level_o(pin_lvl)
    );

    // 40 MHz clock
    initial
    begin
        clock_i = 1'h0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] want);
        total_checks++;
        if (got !== want)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i  <= 1'h1;
        addr  <= a;
        wdata <= d;
        @(posedge clock_i);
        wr_i  <= 1'h0;
    endtask
    // Read word is taken just after the edge that follows the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge clock_i);
        rd_i <= 1'h1;
        addr <= a;
        @(posedge clock_i);
        rd_i <= 1'h0;
        #1;
        rdata = dut_u.rd_data_o;
    endtask
    task automatic rst();
        @(posedge clock_i);
        resetn_i <= 1'h0;
        repeat (4) @(posedge clock_i);
        resetn_i <= 1'h1;
    endtask
    task automatic spin(input logic up, input int n);
        repeat (n * 8)
        begin
            @(posedge clock_i);
            sens.angle <= sens.angle + (up ? 8'h20 : 8'hE0);
        end
        repeat (2) @(posedge clock_i);
    endtask
    task automatic pulse();
        @(posedge clock_i);
        cnt <= 6'h01;
        go  <= 1'h1;
        @(posedge clock_i);
        go  <= 1'h0;
        for (int k = 0; k < 100 && busy; k++)
            @(posedge clock_i);
        repeat (6) @(posedge clock_i);
    endtask
    // Angle or turn word with even parity over the low 16 bits
    function automatic logic [47:0] word(input logic [7:0] b);
        logic [14:0] u;
        u = {sens.lock & !sleep, sens.agc, b};
        return {32'h0, u, ^u};
    endfunction
    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Cuts a hang short
    initial
    begin
        #2000000;
        n_fail++;
        test_done();
    end

    initial
    begin
        {resetn_i, wr_i, rd_i, go, sleep} = 5'h00;
        {addr, wdata, cnt} = 27'h0;
        sens = '{1'h1, 6'h20, 8'h10};
        rst();
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'h00));
        for (int r = 0; r < 16; r++)
        begin
            rst();
            wr(otp_turn_pkg::CMD_BURN, {r[3:0], 12'h000});
            rd(otp_turn_pkg::CMD_RD_FUSE);
            exp = {2'h0, TRIM, r[3:0], 12'h000};
            if (r >= 1 && r <= 12)
                exp[r-1] = 1'h1;
            chk(rdata, exp);
        end
        rst();
        wr(otp_turn_pkg::CMD_BURN, 16'h2A04);
        wr(otp_turn_pkg::CMD_BURN, 16'h0000);
        rd(otp_turn_pkg::CMD_RD_FUSE);
        chk(rdata, {2'h0, TRIM, 16'h2A06});
        chk(48'(gain), 48'h5);
        rd(otp_turn_pkg::CMD_RD_ANALOG);
        chk(48'(oe_n), 48'h0);
        exp = {2'h0, TRIM, 16'h2A04};
        for (int b = 0; b < 46; b++)
        begin
            pulse();
            chk(48'(pin_lvl), 48'(exp[b]));
        end
        pulse();
        chk(48'(oe_n), 48'h1);
        spin(1'h1, 1);
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'h01));
        spin(1'h1, 126);
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'h7F));
        spin(1'h1, 1);
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'h80));
        spin(1'h0, 1);
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'h7F));
        spin(1'h0, 128);
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'hFF));
        wr(otp_turn_pkg::CMD_HYST, 16'h0001);
        pulse();
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'h00));
        wr(otp_turn_pkg::CMD_HYST, 16'h0001);
        pulse();
        spin(1'h1, 1);
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'h01));
        sens.lock <= 1'h0;
        rd(otp_turn_pkg::CMD_RD_ANGLE);
        chk(rdata, word(sens.angle));
        sens.lock <= 1'h1;
        wr(otp_turn_pkg::CMD_CONFIG, 16'h0001);
        sleep = 1'h1;
        rd(otp_turn_pkg::CMD_RD_ANGLE);
        chk(rdata, word(sens.angle));
        rd(otp_turn_pkg::CMD_RD_TURNS);
        chk(rdata, word(8'h01));
        wr(otp_turn_pkg::CMD_CONFIG, 16'h0000);
        sleep = 1'h0;
        sens.agc <= 6'h3F;
        rd(otp_turn_pkg::CMD_RD_ANGLE);
        chk(rdata, word(sens.angle));
        chk(48'(low_f), 48'h0);
        sens.agc <= 6'h3E;
        repeat (2) @(posedge clock_i);
        chk(48'(low_f), 48'h1);
        sens.agc <= 6'h20;
        rd(otp_turn_pkg::CMD_RD_ANGLE);
        chk(48'(rdata[15] & (rdata[14:9] inside {[1:46]})), 48'h1);
        exp = 48'(rdata[14:9]);
        sens.agc <= 6'h24;
        rd(otp_turn_pkg::CMD_RD_ANGLE);
        chk(48'(rdata[14:9] != exp[5:0]), 48'h1);
        test_done();
    end
endmodule

bind otp_turn_counter_status otp_turn_sva #(.FACTORY_TRIM(FACTORY_TRIM)) sva_u
(
    .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .sensor_i(sensor_i),
    .serial_clock_pin_i(serial_clock_pin_i),
    .fuse_program_pin_i(fuse_program_pin_i), .rd_data_o(rd_data_o),
    .fuse_program_pin_o(fuse_program_pin_o),
    .fuse_program_pin_oe_n_o(fuse_program_pin_oe_n_o),
    .low_field_flag_pin_o(low_field_flag_pin_o),
    .gain_setting_o(gain_setting_o)
);
